// ==== fqpd_pkg.sv ====
// Package for the frame queue preheader decoder: field layout, encodings and carrier structs
package fqpd_pkg;

    // -------------------------------------------------------------------------
    // Preheader field positions
    // -------------------------------------------------------------------------
    localparam int PH_SAME_ISOLATION_CONTEXT_ID_BIT   = 63;
    localparam int PH_WRITE_SAFE_BIT  = 62;
    localparam int PH_CRITICAL_RESOURCE_ID_HI         = 59;
    localparam int PH_CRITICAL_RESOURCE_ID_LO         = 56;
    localparam int PH_TBPSIZE_HI      = 50;
    localparam int PH_TBPSIZE_LO      = 48;
    localparam int PH_TABLE_POOL_ID_HI        = 47;
    localparam int PH_TABLE_POOL_ID_LO        = 40;
    localparam int PH_SHARED_DESC_LENGTH_HI        = 37;
    localparam int PH_SHARED_DESC_LENGTH_LO        = 32;
    localparam int PH_KEEP_IN_BIT     = 31;
    localparam int PH_FORCE_SGT_BIT   = 29;
    localparam int PH_LONG_BIT        = 28;
    localparam int PH_OFFSET_HI       = 27;
    localparam int PH_OFFSET_LO       = 26;
    localparam int PH_FIXED_CNT_BIT   = 25;
    localparam int PH_EXTRA_BUF_BIT   = 24;
    localparam int PH_OUTPUT_POOL_ID_HI       = 23;
    localparam int PH_OUTPUT_POOL_ID_LO       = 16;
    localparam int PH_POOLSIZE_HI     = 15;
    localparam int PH_POOLSIZE_LO     = 0;

    // -------------------------------------------------------------------------
    // Constants
    // -------------------------------------------------------------------------
    localparam logic [63:0] SD_OFFSET_BYTES   = 64'h0000_0000_0000_0008;
    localparam logic [12:0] TBL_BASE_BYTES    = 13'h0040;
    localparam logic [16:0] POOL_ZERO_SIZE    = 17'h1_0000;
    localparam logic [1:0]  CNT_ONE           = 2'h1;
    localparam logic [1:0]  CNT_THREE         = 2'h3;
    localparam logic [1:0]  ALLOC_NEEDED      = 2'h0;
    localparam logic [1:0]  ALLOC_NEEDED_PLUS = 2'h1;
    localparam logic [1:0]  ALLOC_NONE        = 2'h2;
    localparam logic [1:0]  ALLOC_ONE         = 2'h3;
    localparam int          FD_SHORT_LEN_W    = 20;
    localparam int          FD_LONG_LEN_W     = 29;
    localparam int          FIFO_D_DEF        = 8;

    // -------------------------------------------------------------------------
    // Carrier types
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  frame_count;
        logic [63:0] context_a;
        logic [23:0] context_b;
    } fqpd_summary_t;

    typedef struct packed {
        logic        same_isolation_context_id_required;
        logic        write_safe_enable;
        logic [3:0]  critical_resource_id;
        logic [2:0]  table_pool_size;
        logic [12:0] table_buf_bytes;
        logic [7:0]  table_pool_id;
        logic [5:0]  shared_desc_length;
        logic        keep_input_frame;
        logic        force_sg_table;
        logic        long_format;
        logic [1:0]  offset_bursts;
        logic        fixed_count_select;
        logic        extra_buffer_request;
        logic [7:0]  output_pool_id;
        logic [16:0] pool_buf_bytes;
    } fqpd_decode_t;

    typedef struct packed {
        logic [63:0] frame_record;
        logic [23:0] response_queue;
        logic [63:0] shared_desc_addr;
        logic        shared_desc_present;
        logic        inline_desc_expected;
        logic        build_output;
        logic        use_sg_table;
        logic        table_from_alt_pool;
        logic [7:0]  data_pool_id;
        logic [1:0]  alloc_mode;
        logic        allocate_output;
        logic        build_compound;
        logic        priority_lowered;
        logic        last_of_dequeue;
    } fqpd_job_t;

    // Job buffer default width carries one whole job record
    localparam int FIFO_W_DEF = $bits(fqpd_job_t);

    typedef enum logic [1:0] {
        FQPD_IDLE,
        FQPD_FETCH,
        FQPD_FRAMES
    } fqpd_state_t;

endpackage : fqpd_pkg

// ==== fqpd_fifo.sv ====
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
`default_nettype none
module fqpd_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count < (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule // fqpd_fifo
`default_nettype wire

// ==== fqpd_decode.sv ====
// Frame queue dequeue front end with preheader decode
// Function
// - Summary applies to exactly the dequeued frame count, one to three frames.
// - First context value is the preheader address for all frames.
// - Second context value names the response queue for result frames.
// - Shared descriptor is fetched at preheader address plus eight bytes.
// - No shared descriptor means in-line descriptor expected, else error completion.
// - Bit 63 set and differing sharing identifiers gives error, no execution.
// - Bit 62 enables write-safe for sequence stores into output frame.
// - Nonzero critical resource, fully used by other flows, lowers priority.
// - Table pool size 000 disables; 001..111 give 64 to 4096 bytes.
// - Nonzero table pool size takes table buffers from table pool id.
// - Bits 37-32 give shared descriptor words; zero means none.
// - Bit 31 keeps input frame and builds a compound frame.
// - Allocation fields used only when output needed and not supplied.
// - Force-table bit builds a table whenever output is built; else only for multi-buffer.
// - Long format gives 29-bit length, no offset; else 20-bit plus offset.
// - Fixed-count and extra bits: needed, needed+1, none, exactly one.
// - Pool size zero means 64k; its lowest bit is taken as zero.
`timescale 1ns/1ps
`default_nettype none
module fqpd_decode
    import fqpd_pkg::*;
#(
    parameter int FIFO_WIDTH = FIFO_W_DEF,
    parameter int FIFO_DEPTH = FIFO_D_DEF
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    // Dequeue summary from the queue manager
    input  wire fqpd_summary_t dq_summary,
    input  wire logic          dq_valid,
    output logic               dq_ready,
    // Frame records of the dequeue
    input  wire logic [63:0]   frame_record,
    input  wire logic          frame_valid,
    output logic               frame_ready,
    // Preheader memory read
    output logic               ph_req,
    output logic [63:0]        ph_addr,
    input  wire logic          ph_ack,
    input  wire logic [63:0]   ph_data,
    // Per-job hints from the frame and the scheduler
    input  wire logic          out_frame_supplied,
    input  wire logic          multi_buffer_needed,
    input  wire logic          inline_desc_found,
    input  wire logic          isolation_context_id_mismatch,
    input  wire logic          resource_all_busy,
    // Decoded preheader and job outputs
    output fqpd_decode_t       decoded,
    output fqpd_job_t          job,
    output logic               job_valid,
    input  wire logic          job_ready,
    output logic               job_error,
    output logic               share_error,
    output logic               write_safe
);
    // -------------------------------------------------------------------------
    // Decode helpers
    // -------------------------------------------------------------------------
    function automatic logic [12:0] table_bytes(input logic [2:0] code);
        table_bytes = (code == 3'h0) ? 13'h0000 : (TBL_BASE_BYTES << (code - 3'h1));
    endfunction

    function automatic fqpd_decode_t decode_ph(input logic [63:0] ph);
        fqpd_decode_t d;
        d.same_isolation_context_id_required   = ph[PH_SAME_ISOLATION_CONTEXT_ID_BIT];
        d.write_safe_enable    = ph[PH_WRITE_SAFE_BIT];
        d.critical_resource_id = ph[PH_CRITICAL_RESOURCE_ID_HI:PH_CRITICAL_RESOURCE_ID_LO];
        d.table_pool_size      = ph[PH_TBPSIZE_HI:PH_TBPSIZE_LO];
        d.table_buf_bytes      = table_bytes(ph[PH_TBPSIZE_HI:PH_TBPSIZE_LO]);
        d.table_pool_id        = ph[PH_TABLE_POOL_ID_HI:PH_TABLE_POOL_ID_LO];
        d.shared_desc_length   = ph[PH_SHARED_DESC_LENGTH_HI:PH_SHARED_DESC_LENGTH_LO];
        d.keep_input_frame     = ph[PH_KEEP_IN_BIT];
        d.force_sg_table       = ph[PH_FORCE_SGT_BIT];
        d.long_format          = ph[PH_LONG_BIT];
        d.offset_bursts        = ph[PH_LONG_BIT] ? 2'h0 : ph[PH_OFFSET_HI:PH_OFFSET_LO];
        d.fixed_count_select   = ph[PH_FIXED_CNT_BIT];
        d.extra_buffer_request = ph[PH_EXTRA_BUF_BIT];
        d.output_pool_id       = ph[PH_OUTPUT_POOL_ID_HI:PH_OUTPUT_POOL_ID_LO];
        d.pool_buf_bytes       = (ph[PH_POOLSIZE_HI:PH_POOLSIZE_LO] == 16'h0000) ? POOL_ZERO_SIZE
                               : {1'b0, ph[PH_POOLSIZE_HI:PH_POOLSIZE_LO+1], 1'b0};
        decode_ph = d;
    endfunction

    // -------------------------------------------------------------------------
    // Dequeue sequencing
    // -------------------------------------------------------------------------
    fqpd_state_t   state;
    fqpd_state_t   next_state;
    fqpd_summary_t summary;
    fqpd_summary_t next_summary;
    logic [1:0]    remaining;
    logic [1:0]    next_remaining;
    fqpd_decode_t  next_decoded;
    logic          next_job_error;
    logic          next_share_error;

    fqpd_job_t     built;
    logic          fifo_in_ready;
    logic          take_frame;
    logic [FIFO_WIDTH-1:0] fifo_out;

    assign dq_ready    = (state == FQPD_IDLE);
    assign ph_req      = (state == FQPD_FETCH);
    assign ph_addr     = summary.context_a;
    assign frame_ready = (state == FQPD_FRAMES) && fifo_in_ready;
    assign take_frame  = frame_valid && frame_ready;
    assign write_safe  = decoded.write_safe_enable;

    always_comb begin
        next_state       = state;
        next_summary     = summary;
        next_remaining   = remaining;
        next_decoded     = decoded;
        next_job_error   = 1'b0;
        next_share_error = 1'b0;
        case (state)
            FQPD_IDLE: begin
                if (dq_valid && dq_summary.frame_count != 2'h0) begin
                    next_summary   = dq_summary;
                    next_remaining = (dq_summary.frame_count > CNT_THREE) ? CNT_THREE
                                                                         : dq_summary.frame_count;
                    next_state     = FQPD_FETCH;
                end
            end
            FQPD_FETCH: begin
                if (ph_ack) begin
                    next_decoded = decode_ph(ph_data);
                    next_state   = FQPD_FRAMES;
                end
            end
            FQPD_FRAMES: begin
                if (take_frame) begin
                    next_job_error   = (decoded.shared_desc_length == 6'h00) && !inline_desc_found;
                    next_share_error = decoded.same_isolation_context_id_required && isolation_context_id_mismatch;
                    next_remaining   = remaining - 1'b1;
                    if (remaining == CNT_ONE) begin
                        next_state = FQPD_IDLE;
                    end
                end
            end
            default: begin
                next_state = FQPD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state       <= FQPD_IDLE;
            summary     <= '0;
            remaining   <= '0;
            decoded     <= '0;
            job_error   <= 1'b0;
            share_error <= 1'b0;
        end else begin
            state       <= next_state;
            summary     <= next_summary;
            remaining   <= next_remaining;
            decoded     <= next_decoded;
            job_error   <= next_job_error;
            share_error <= next_share_error;
        end
    end

    // -------------------------------------------------------------------------
    // Job record for each frame
    // -------------------------------------------------------------------------
    always_comb begin
        built                      = '0;
        built.frame_record         = frame_record;
        built.response_queue       = summary.context_b;
        built.shared_desc_present  = (decoded.shared_desc_length != 6'h00);
        built.shared_desc_addr     = summary.context_a + SD_OFFSET_BYTES;
        built.inline_desc_expected = !built.shared_desc_present;
        built.alloc_mode           = {decoded.fixed_count_select, decoded.extra_buffer_request};
        built.allocate_output      = (built.alloc_mode != ALLOC_NONE);
        built.build_output         = built.allocate_output && !out_frame_supplied;
        built.use_sg_table         = built.build_output
                                   && (decoded.force_sg_table || multi_buffer_needed);
        built.table_from_alt_pool  = (decoded.table_pool_size != 3'h0);
        built.data_pool_id         = decoded.output_pool_id;
        built.build_compound       = decoded.keep_input_frame;
        built.priority_lowered     = (decoded.critical_resource_id != 4'h0) && resource_all_busy;
        built.last_of_dequeue      = (remaining == CNT_ONE);
    end

    // -------------------------------------------------------------------------
    // Job buffer
    // -------------------------------------------------------------------------
    fqpd_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_job_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_data   (FIFO_WIDTH'(built)),
        .in_valid  (take_frame),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (job_valid),
        .out_ready (job_ready)
    );

    assign job = fqpd_job_t'(fifo_out);

endmodule // fqpd_decode
`default_nettype wire

// ==== fqpd_decode_chk.sv ====
// Port checker for the frame queue preheader decoder
`timescale 1ns/1ps
`default_nettype none
module fqpd_decode_chk
    import fqpd_pkg::*;
#(
    parameter int FIFO_WIDTH = FIFO_W_DEF,
    parameter int FIFO_DEPTH = FIFO_D_DEF
) (
    input wire logic          mclk,
    input wire logic          rst,
    input wire fqpd_summary_t dq_summary,
    input wire logic          dq_valid,
    input wire logic          dq_ready,
    input wire logic [63:0]   frame_record,
    input wire logic          frame_valid,
    input wire logic          frame_ready,
    input wire logic          ph_req,
    input wire logic [63:0]   ph_addr,
    input wire logic          ph_ack,
    input wire logic [63:0]   ph_data,
    input wire logic          out_frame_supplied,
    input wire logic          multi_buffer_needed,
    input wire logic          inline_desc_found,
    input wire logic          isolation_context_id_mismatch,
    input wire logic          resource_all_busy,
    input wire fqpd_decode_t  decoded,
    input wire fqpd_job_t     job,
    input wire logic          job_valid,
    input wire logic          job_ready,
    input wire logic          job_error,
    input wire logic          share_error,
    input wire logic          write_safe
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_dq_take;
        dq_valid && dq_ready && dq_summary.frame_count != 2'h0;
    endsequence
    sequence s_ph_done;
        ph_req && ph_ack;
    endsequence
    sequence s_fr_take;
        frame_valid && frame_ready;
    endsequence

    a_fetch_addr_ok: assert property (s_dq_take |=> ph_req && ph_addr == $past(dq_summary.context_a))
        else $error("preheader read not at first context value");
    a_fetch_req_holds: assert property (ph_req && !ph_ack |=> ph_req && $stable(ph_addr))
        else $error("preheader read dropped before answer");
    a_frames_wait_ph: assert property (ph_req |-> !frame_ready && !dq_ready)
        else $error("frames or summaries taken before preheader");
    a_shared_desc_length_load: assert property (s_ph_done |=> decoded.shared_desc_length == $past(ph_data[37:32]))
        else $error("shared descriptor length wrong");
    a_write_safe_load: assert property (s_ph_done |=> write_safe == $past(ph_data[PH_WRITE_SAFE_BIT]))
        else $error("write safe level wrong");
    a_tbl_bytes_ok: assert property (s_ph_done |=> decoded.table_buf_bytes ==
        ($past(ph_data[50:48]) == 3'h0 ? 13'h0 : 13'h20 << $past(ph_data[50:48])))
        else $error("table buffer size wrong");
    a_pool_bytes_ok: assert property (s_ph_done |=> decoded.pool_buf_bytes ==
        ($past(ph_data[15:0]) == 16'h0 ? POOL_ZERO_SIZE : {1'b0, $past(ph_data[15:1]), 1'b0}))
        else $error("pool buffer size wrong");
    a_share_err_ok: assert property (s_fr_take |=> share_error == ($past(isolation_context_id_mismatch) && decoded.same_isolation_context_id_required))
        else $error("sharing error flag wrong");
    a_inline_err_ok: assert property (s_fr_take |=>
        job_error == (decoded.shared_desc_length == 6'h0 && !$past(inline_desc_found)))
        else $error("in-line descriptor error flag wrong");
    a_job_held: assert property (job_valid && !job_ready |=> job_valid && $stable(job))
        else $error("job changed while stalled");
endmodule // fqpd_decode_chk

bind fqpd_decode fqpd_decode_chk #(.FIFO_WIDTH(FIFO_WIDTH), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (
    .mclk(mclk), .rst(rst), .dq_summary(dq_summary), .dq_valid(dq_valid), .dq_ready(dq_ready),
    .frame_record(frame_record), .frame_valid(frame_valid), .frame_ready(frame_ready), .ph_req(ph_req),
    .ph_addr(ph_addr), .ph_ack(ph_ack), .ph_data(ph_data), .out_frame_supplied(out_frame_supplied),
    .multi_buffer_needed(multi_buffer_needed), .inline_desc_found(inline_desc_found),
    .isolation_context_id_mismatch(isolation_context_id_mismatch), .resource_all_busy(resource_all_busy), .decoded(decoded), .job(job),
    .job_valid(job_valid), .job_ready(job_ready), .job_error(job_error), .share_error(share_error),
    .write_safe(write_safe));
`default_nettype wire

// ==== fqpd_mem_model.sv ====
// Memory model that answers preheader reads after a set wait
`timescale 1ns/1ps
`default_nettype none
module fqpd_mem_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ph_req,
    input  wire logic [63:0] ph_addr,
    input  wire logic [3:0]  wait_cycles,
    output logic             ph_ack,
    output logic      [63:0] ph_data
);
    logic [63:0] mem [0:3];
    logic [3:0]  cnt;

    always @(posedge mclk) begin
        if (rst) begin
            cnt     <= 4'h0;
            ph_ack  <= 1'b0;
            ph_data <= 64'h0;
        end else if (ph_req && !ph_ack && cnt >= wait_cycles) begin
            cnt     <= 4'h0;
            ph_ack  <= 1'b1;
            ph_data <= mem[ph_addr[4:3]];
        end else begin
            cnt     <= (ph_req && !ph_ack) ? cnt + 4'h1 : 4'h0;
            ph_ack  <= 1'b0;
            // Data outside the answer is not held
            ph_data <= ~ph_data;
        end
    end
endmodule // fqpd_mem_model
`default_nettype wire

// ==== test_fqpd_decode.sv ====
// Self-checking testbench for the frame queue preheader decoder
`timescale 1ns/1ps
`default_nettype none
module test_fqpd_decode;
    import fqpd_pkg::*;
    localparam int FW = $bits(fqpd_job_t);
    logic          mclk = 1'b0, rst = 1'b1, dq_valid = 1'b0, frame_valid = 1'b0, job_ready = 1'b1;
    logic          dq_ready, frame_ready, ph_req, ph_ack, job_valid, job_error, share_error, write_safe, je, se;
    logic [63:0]   frame_record = 64'h0, ph_addr, ph_data;
    logic [4:0]    h = 5'h0;
    logic [3:0]    wait_cycles = 4'h0;
    fqpd_summary_t dq_summary = '0;
    fqpd_decode_t  decoded;
    fqpd_job_t     job;
    fqpd_job_t     jq[$];
    int            n_mismatch = 0, n_checks = 0;

    always #12.5 mclk = ~mclk;

    fqpd_decode #(.FIFO_WIDTH(FW), .FIFO_DEPTH(8)) i_dut (
        .mclk(mclk), .rst(rst), .dq_summary(dq_summary), .dq_valid(dq_valid), .dq_ready(dq_ready),
        .frame_record(frame_record), .frame_valid(frame_valid), .frame_ready(frame_ready),
        .ph_req(ph_req), .ph_addr(ph_addr), .ph_ack(ph_ack), .ph_data(ph_data),
        .out_frame_supplied(h[4]), .multi_buffer_needed(h[3]), .inline_desc_found(h[2]),
        .isolation_context_id_mismatch(h[1]), .resource_all_busy(h[0]), .decoded(decoded), .job(job),
        .job_valid(job_valid), .job_ready(job_ready), .job_error(job_error),
        .share_error(share_error), .write_safe(write_safe));

    fqpd_mem_model i_mem (.mclk(mclk), .rst(rst), .ph_req(ph_req), .ph_addr(ph_addr),
        .wait_cycles(wait_cycles), .ph_ack(ph_ack), .ph_data(ph_data));

    always @(posedge mclk) if (!rst && job_valid === 1'b1 && job_ready) jq.push_back(job);

    // ------------------------------------------------------------------
    // Drivers and compare
    // ------------------------------------------------------------------
    task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic deq(input logic [63:0] p, input logic [63:0] a, input logic [23:0] b, input logic [1:0] n);
        int k;
        k = 0;
        i_mem.mem[a[4:3]] = p;
        while (dq_ready !== 1'b1 && k < 50) begin
            @(negedge mclk);
            k++;
        end
        dq_summary = '{n, a, b};
        dq_valid = 1'b1;
        @(negedge mclk);
        dq_valid = 1'b0;
        chk("ph_addr", a, ph_addr);
        repeat (20) if (frame_ready !== 1'b1) @(negedge mclk);
    endtask

    task automatic frm(input logic [4:0] hv, input logic more);
        int k;
        k = 0;
        h = hv;
        frame_record = frame_record + 64'h1;
        if (!frame_valid) frame_valid = 1'b1;
        while (frame_ready !== 1'b1 && k < 50) begin
            @(negedge mclk);
            k++;
        end
        @(negedge mclk);
        je = job_error;
        se = share_error;
        frame_valid = more;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_basic();
        logic [63:0] p, a;
        p = 64'he283_5a05_d17f_0000;
        a = 64'h0000_1000_0000_0008;
        jq.delete();
        deq(p, a, 24'habcdef, 2'h3);
        chk("shared_desc_length", p[37:32], decoded.shared_desc_length);
        chk("tbl_bytes", 64'h100, decoded.table_buf_bytes);
        chk("tbl_pool", p[47:40], decoded.table_pool_id);
        chk("pool_bytes", 64'h10000, decoded.pool_buf_bytes);
        chk("critical_resource_id", 64'h2, decoded.critical_resource_id);
        chk("keep_in", 64'h1, decoded.keep_input_frame);
        chk("long", 64'h1, decoded.long_format);
        chk("write_safe", 64'h1, write_safe);
        frm(5'b01010, 1'b1);
        chk("share_err", 64'h1, se);
        chk("job_err", 64'h0, je);
        frm(5'b00001, 1'b1);
        chk("share_err", 64'h0, se);
        frm(5'b10000, 1'b0);
        repeat (3) @(negedge mclk);
        chk("jobs", 64'h3, jq.size());
        foreach (jq[i]) begin
            chk("resp_q", 64'habcdef, jq[i].response_queue);
            chk("sd_addr", a + 64'h8, jq[i].shared_desc_addr);
            chk("last", i == 2, jq[i].last_of_dequeue);
            chk("compound", 64'h1, jq[i].build_compound);
            chk("alloc", 64'h1, jq[i].alloc_mode);
            chk("alt_pool", 64'h1, jq[i].table_from_alt_pool);
            chk("prio", i == 1, jq[i].priority_lowered);
            chk("alloc_out", 64'h1, jq[i].allocate_output);
            chk("build_out", i != 2, jq[i].build_output);
            chk("sg_table", i == 0, jq[i].use_sg_table);
            chk("data_pool", p[23:16], jq[i].data_pool_id);
        end
        $display("t_basic done");
    endtask

    task automatic t_inline();
        wait_cycles = 4'h6;
        jq.delete();
        deq(64'h0000_0000_2333_0123, 64'h10, 24'h000042, 2'h2);
        chk("pool_bytes", 64'h122, decoded.pool_buf_bytes);
        chk("tbl_bytes", 64'h0, decoded.table_buf_bytes);
        chk("write_safe", 64'h0, write_safe);
        frm(5'b00000, 1'b1);
        chk("job_err", 64'h1, je);
        frm(5'b00110, 1'b0);
        chk("job_err", 64'h0, je);
        chk("share_err", 64'h0, se);
        repeat (3) @(negedge mclk);
        chk("jobs", 64'h2, jq.size());
        foreach (jq[i]) begin
            chk("sd_present", 64'h0, jq[i].shared_desc_present);
            chk("inline", 64'h1, jq[i].inline_desc_expected);
            chk("sg_table", 64'h1, jq[i].use_sg_table);
            chk("alt_pool", 64'h0, jq[i].table_from_alt_pool);
            chk("alloc", 64'h3, jq[i].alloc_mode);
            chk("compound", 64'h0, jq[i].build_compound);
        end
        $display("t_inline done");
    endtask

    task automatic t_codes();
        logic [63:0] p;
        for (int k = 0; k < 8; k++) begin
            p = {13'h0, k[2:0], 8'h0, 8'h01, 3'h0, k[0], k[2:1], k[1:0], 24'h0};
            wait_cycles = k[3:0];
            deq(p, 64'h18, 24'h7, 2'h1);
            chk("tbl_bytes", k == 0 ? 64'h0 : 64'h20 << k, decoded.table_buf_bytes);
            chk("long", k[0], decoded.long_format);
            chk("offset", k[0] ? 64'h0 : 64'(k[2:1]), decoded.offset_bursts);
            frm(5'b00100, 1'b0);
            repeat (3) @(negedge mclk);
            chk("alloc", k[1:0], jq[$].alloc_mode);
        end
        $display("t_codes done");
    endtask

    task automatic t_full();
        wait_cycles = 4'h0;
        job_ready = 1'b0;
        jq.delete();
        repeat (4) begin
            deq(64'h0000_0001_0000_0040, 64'h8, 24'h9, 2'h2);
            frm(5'b00100, 1'b1);
            frm(5'b00100, 1'b0);
        end
        deq(64'h0000_0001_0000_0040, 64'h8, 24'h9, 2'h1);
        repeat (4) begin
            @(negedge mclk);
            chk("refused", 64'h0, frame_ready);
        end
        job_ready = 1'b1;
        frm(5'b00100, 1'b0);
        repeat (12) @(negedge mclk);
        chk("jobs", 64'h9, jq.size());
        foreach (jq[i]) chk("last", i % 2 == 1 || i == 8, jq[i].last_of_dequeue);
        $display("t_full done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        t_basic();
        t_inline();
        t_codes();
        t_full();
        test_done();
    end

    initial begin
        #(25.0 * 20000);
        n_mismatch++;
        test_done();
    end
endmodule // test_fqpd_decode
`default_nettype wire
